// File: shared/mps_defs.svh
// Constants for the motion program sequencer
// Functional notes
// RQ1 - Wait-for-input step holds until program input one is asserted.
// RQ2 - Input one after a dwell is accepted only once the dwell elapsed.
// RQ3 - Interrupt positioning stops exactly the set distance past the input edge.
// RQ4 - Interrupt step skipped when prior move is shorter than its distance.
// RQ5 - Program author puts a wait-for-input step before each interrupt step.
// RQ6 - Short interrupt distance shortens deceleration below the programmed constant; code asserts o_fast_decel on every interrupt move, short or not.
// RQ7 - Pulse count wait holds until accumulated generator pulses exceed the value.
// RQ8 - Pulse count step with zero clears the accumulated count and proceeds.
// RQ9 - Steps between loop start and loop end run the loop value times.
// RQ10 - Program author never nests step repeat loops.
// RQ11 - Program repeat step runs program n times; zero endless; absent once.
// RQ12 - Dwell delays next step by its time after remaining travel reaches zero.
// RQ13 - Trip point steps wait until axis passes address or covers distance.
// RQ14 - Program end step stops, or restarts while repetitions remain.
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH
`define MPS_PC_W        8
`define MPS_ARG_W       32
`define MPS_OP_W        4
`define MPS_STEP_W      36
`define MPS_CLK_MHZ     100
`define MPS_MS_NS       1000000
`define MPS_CLK_NS      10
`define MPS_MS_CYCLES   (`MPS_MS_NS / `MPS_CLK_NS)
`define MPS_OP_NOP      4'h0
`define MPS_OP_MOVE     4'h1
`define MPS_OP_DWELL    4'h2
`define MPS_OP_SYNC     4'h3
`define MPS_OP_ITP      4'h4
`define MPS_OP_COUNT    4'h5
`define MPS_OP_FOR      4'h6
`define MPS_OP_NEXT     4'h7
`define MPS_OP_TIMES    4'h8
`define MPS_OP_TRIP     4'h9
`define MPS_OP_STOP     4'hF
`endif

// File: shared/mps_pkg.sv
// Types for the motion program sequencer
package mps_pkg;
  typedef enum logic [3:0] {
    MPS_IDLE, MPS_FETCH, MPS_WAITRD, MPS_EXEC, MPS_MOVE_W, MPS_DWELL_W,
    MPS_SYNC_W, MPS_ITP_W, MPS_COUNT_W, MPS_TRIP_W
  } mps_state_t;
endpackage

// File: hw/mps_prog_mem.sv
// Program step memory with registered read data
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_prog_mem (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_we,
  input  wire logic [`MPS_PC_W-1:0]   i_waddr,
  input  wire logic [`MPS_STEP_W-1:0] i_wdata,
  input  wire logic [`MPS_PC_W-1:0]   i_raddr,
  output logic      [`MPS_STEP_W-1:0] o_rdata
);
  logic [`MPS_STEP_W-1:0] mem [0:(1<<`MPS_PC_W)-1];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// File: hw/mps_sequencer.sv
// Step sequencer for a stored positioning program
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_sequencer
  import mps_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_prog_we,
  input  wire logic [`MPS_PC_W-1:0]   i_prog_addr,
  input  wire logic [`MPS_STEP_W-1:0] i_prog_data,
  input  wire logic                   i_start,
  input  wire logic                   i_program_input_one,
  input  wire logic                   i_mpg_pulse,
  input  wire logic                   i_move_done,
  input  wire logic signed [`MPS_ARG_W-1:0] i_position,
  output logic                        o_busy,
  output logic                        o_move_start,
  output logic                        o_move_rel,
  output logic                        o_move_cont,
  output logic signed [`MPS_ARG_W-1:0] o_move_target,
  output logic                        o_itp_active,
  output logic                        o_fast_decel,
  output logic [`MPS_ARG_W-1:0]       o_mpg_count,
  output logic [`MPS_PC_W-1:0]        o_step
);
  // Signed distance magnitude, used for move sizes and trip checks
  function automatic logic [`MPS_ARG_W-1:0] mps_abs(
    input logic signed [`MPS_ARG_W-1:0] v);
    mps_abs = v[`MPS_ARG_W-1] ? (`MPS_ARG_W)'(-v) : v;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] pi_sync;
  logic [2:0] mpg_sync;
  logic       pi_level;
  logic       mpg_level;
  logic       mpg_prev;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pi_sync   <= 3'h0;
      mpg_sync  <= 3'h0;
      pi_level  <= 1'b0;
      mpg_level <= 1'b0;
      mpg_prev  <= 1'b0;
    end else begin
      pi_sync  <= {pi_sync[1:0], i_program_input_one};
      mpg_sync <= {mpg_sync[1:0], i_mpg_pulse};
      if (pi_sync[2] == pi_sync[1]) begin
        pi_level <= pi_sync[1];
      end
      if (mpg_sync[2] == mpg_sync[1]) begin
        mpg_level <= mpg_sync[1];
      end
      mpg_prev <= mpg_level;
    end
  end
  wire mpg_rise = mpg_level & ~mpg_prev;

  // ****************************************
  // Step decode
  // ****************************************
  mps_state_t             state;
  mps_state_t             next_state;
  logic [`MPS_PC_W-1:0]   pc;
  logic [`MPS_STEP_W-1:0] step_word;
  logic [`MPS_PC_W-1:0]   loop_pc;
  logic [`MPS_ARG_W-1:0]  loop_left;
  logic [`MPS_ARG_W-1:0]  runs_left;
  logic                   endless;
  logic [`MPS_ARG_W-1:0]  last_move;
  logic [`MPS_ARG_W-1:0]  ms_left;
  logic [31:0]            tick_cnt;
  logic signed [`MPS_ARG_W-1:0] trip_base;
  logic                   mpg_clear;
  logic                   first_run;
  // Read data moves on once pc advances, so waits use this copy
  logic [`MPS_ARG_W-1:0]  wait_arg;

  mps_prog_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_we      (i_prog_we),
    .i_waddr   (i_prog_addr),
    .i_wdata   (i_prog_data),
    .i_raddr   (pc),
    .o_rdata   (step_word)
  );

  wire [`MPS_OP_W-1:0]         op   = step_word[`MPS_STEP_W-1:`MPS_ARG_W];
  wire [`MPS_ARG_W-1:0]        arg  = step_word[`MPS_ARG_W-1:0];
  wire signed [`MPS_ARG_W-1:0] sarg = step_word[`MPS_ARG_W-1:0];
  wire [`MPS_PC_W-1:0]         pc_next = pc + `MPS_PC_W'(1);
  wire                         ms_tick = (tick_cnt == 32'h0);
  // Trip argument: sign bit 0 = absolute address, else travel distance
  wire [`MPS_ARG_W-2:0]        trip_val = wait_arg[`MPS_ARG_W-2:0];
  wire trip_hit = wait_arg[`MPS_ARG_W-1] ?
    (mps_abs(i_position - trip_base) >= {1'b0, trip_val}) :
    (((trip_base <= $signed({1'b0, trip_val})) &&
      (i_position >= $signed({1'b0, trip_val}))) ||
     ((trip_base > $signed({1'b0, trip_val})) &&
      (i_position <= $signed({1'b0, trip_val}))));

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      MPS_IDLE:    if (i_start) next_state = MPS_FETCH;
      MPS_FETCH:   next_state = MPS_WAITRD;
      MPS_WAITRD:  next_state = MPS_EXEC;
      MPS_EXEC: begin
        case (op)
          `MPS_OP_MOVE:  next_state = MPS_MOVE_W;
          `MPS_OP_DWELL: next_state = MPS_DWELL_W;
          `MPS_OP_SYNC:  next_state = MPS_SYNC_W;
          `MPS_OP_ITP:   next_state = (last_move < arg) ? MPS_FETCH :
                                      MPS_ITP_W; // RQ4
          `MPS_OP_COUNT: next_state = (arg == 32'h0) ? MPS_FETCH :
                                      MPS_COUNT_W; // RQ8
          `MPS_OP_TRIP:  next_state = MPS_TRIP_W;
          `MPS_OP_STOP:  next_state = (endless || runs_left > 32'h1) ?
                                      MPS_FETCH : MPS_IDLE; // RQ14
          default:       next_state = MPS_FETCH;
        endcase
      end
      MPS_MOVE_W:  if (i_move_done) next_state = MPS_FETCH;
      // Remaining travel must reach zero before the dwell counts
      MPS_DWELL_W: if (i_move_done && ms_left == 32'h0) begin
        next_state = MPS_FETCH; // RQ12 RQ2
      end
      MPS_SYNC_W:  if (pi_level) next_state = MPS_FETCH; // RQ1
      MPS_ITP_W:   if (i_move_done) next_state = MPS_FETCH; // RQ3
      MPS_COUNT_W: if (o_mpg_count > wait_arg) begin
        next_state = MPS_FETCH; // RQ7
      end
      MPS_TRIP_W:  if (trip_hit) next_state = MPS_FETCH; // RQ13
      default:     next_state = MPS_IDLE;
    endcase
  end

  wire in_exec = (state == MPS_EXEC);
  assign mpg_clear = in_exec && op == `MPS_OP_COUNT && arg == 32'h0; // RQ8

  // ****************************************
  // Sequencing registers
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state     <= MPS_IDLE;
      pc        <= `MPS_PC_W'(0);
      loop_pc   <= `MPS_PC_W'(0);
      loop_left <= 32'h0;
      runs_left <= 32'h1;
      endless   <= 1'b0;
      first_run <= 1'b1;
      wait_arg  <= 32'h0;
    end else begin
      state <= next_state;
      if (state == MPS_IDLE) begin
        pc        <= `MPS_PC_W'(0);
        runs_left <= 32'h1; // RQ11
        endless   <= 1'b0;
        first_run <= 1'b1;
      end else if (in_exec) begin
        pc       <= pc_next;
        wait_arg <= arg;
        case (op)
          // Later passes must not reload the repeat count
          `MPS_OP_TIMES: if (pc == `MPS_PC_W'(0) && first_run) begin
            runs_left <= arg; // RQ11
            endless   <= (arg == 32'h0);
          end
          `MPS_OP_FOR: begin
            loop_pc   <= pc_next; // RQ9
            loop_left <= arg;
          end
          `MPS_OP_NEXT: if (loop_left > 32'h1) begin
            loop_left <= loop_left - 32'h1; // RQ9
            pc        <= loop_pc;
          end
          `MPS_OP_STOP: begin
            pc        <= `MPS_PC_W'(0); // RQ14
            first_run <= 1'b0;
            if (!endless && runs_left > 32'h1) begin
              runs_left <= runs_left - 32'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Dwell timer, 1 ms enable
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tick_cnt <= 32'h0;
      ms_left  <= 32'h0;
    end else if (in_exec && op == `MPS_OP_DWELL) begin
      tick_cnt <= 32'(`MPS_MS_CYCLES - 1);
      ms_left  <= arg;
    end else if (state == MPS_DWELL_W && i_move_done && ms_left != 0) begin
      tick_cnt <= ms_tick ? 32'(`MPS_MS_CYCLES - 1) : tick_cnt - 32'h1;
      if (ms_tick) begin
        ms_left <= ms_left - 32'h1; // RQ12
      end
    end
  end

  // ****************************************
  // Pulse counter and motion commands
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mpg_count   <= 32'h0;
      o_move_start  <= 1'b0;
      o_move_rel    <= 1'b0;
      o_move_cont   <= 1'b0;
      o_move_target <= '0;
      o_itp_active  <= 1'b0;
      o_fast_decel  <= 1'b0;
      last_move     <= 32'h0;
      trip_base     <= '0;
    end else begin
      if (mpg_clear) begin
        // A pulse landing in the clearing cycle is kept
        o_mpg_count <= mpg_rise ? 32'h1 : 32'h0; // RQ8
      end else if (mpg_rise) begin
        o_mpg_count <= o_mpg_count + 32'h1; // RQ7
      end
      o_move_start <= 1'b0;
      if (in_exec && op == `MPS_OP_MOVE) begin
        // Bit 31 relative, bit 30 continuous; 30-bit signed amount
        o_move_start  <= 1'b1;
        o_move_rel    <= arg[31];
        o_move_cont   <= arg[30];
        o_move_target <= {{2{arg[29]}}, arg[29:0]};
        last_move <= arg[31] ? mps_abs({{2{arg[29]}}, arg[29:0]}) :
                     mps_abs({{2{arg[29]}}, arg[29:0]} - i_position);
        trip_base <= i_position;
      end
      if (in_exec && op == `MPS_OP_ITP && last_move >= arg) begin
        // Stop point is the step distance relative to where the axis is when this step executes
        o_move_start  <= 1'b1; // RQ3
        o_move_rel    <= 1'b1;
        o_move_cont   <= 1'b0;
        o_move_target <= sarg;
        o_itp_active  <= 1'b1;
        // Every interrupt move forces the shorter ramp, whatever its distance
        o_fast_decel  <= 1'b1; // RQ6
      end else if (state == MPS_ITP_W && i_move_done) begin
        o_itp_active <= 1'b0;
        o_fast_decel <= 1'b0;
      end
    end
  end

  assign o_busy = (state != MPS_IDLE);
  assign o_step = pc;
endmodule

// File: test/mps_sequencer_assertions.sv
// Port checker for the motion program sequencer
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_seq_checker (
  input wire logic                        i_sys_clk,
  input wire logic                        i_rst,
  input wire logic                        i_start,
  input wire logic                        i_mpg_pulse,
  input wire logic                        o_busy,
  input wire logic                        o_move_start,
  input wire logic signed [`MPS_ARG_W-1:0] o_move_target,
  input wire logic                        o_itp_active,
  input wire logic                        o_fast_decel,
  input wire logic [`MPS_ARG_W-1:0]       o_mpg_count
);
  // ***
  // Properties
  // ***
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_ITP_DECEL: assert property (o_itp_active |-> o_fast_decel)
    else $error("fast decel missing during interrupt move");
  AST_CNT_STEP: assert property ($changed(o_mpg_count) && o_mpg_count != 0
    |-> o_mpg_count == $past(o_mpg_count) + 32'h1 ||
        o_mpg_count == 32'h1)
    else $error("pulse count jumped");
  // Filter latency is a few cycles, six quiet cycles leave margin
  AST_CNT_QUIET: assert property (!i_mpg_pulse [*6]
    |=> $stable(o_mpg_count) || o_mpg_count == 0)
    else $error("count moved without pulses");
  AST_START_TAKE: assert property (!o_busy && i_start |=> o_busy)
    else $error("start not taken while idle");
  AST_IDLE_QUIET: assert property (!o_busy
    |-> !o_move_start && !o_itp_active)
    else $error("motion command while idle");
  AST_MOVE_GAP: assert property (o_move_start
    |=> !o_move_start [*2])
    else $error("move commands too close");
  AST_TGT_HOLD: assert property ($changed(o_move_target)
    |-> o_move_start || o_itp_active)
    else $error("target changed without a command");
  AST_ITP_BUSY: assert property (o_itp_active |-> o_busy)
    else $error("interrupt move outside a run");
  cover property (o_itp_active);
  cover property ($fell(o_busy));
  cover property (o_mpg_count == 32'h0 && $past(o_mpg_count) != 32'h0);
endmodule
bind mps_sequencer mps_seq_checker u_chk (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_start(i_start), .i_mpg_pulse(i_mpg_pulse),
  .o_busy(o_busy), .o_move_start(o_move_start),
  .o_move_target(o_move_target), .o_itp_active(o_itp_active),
  .o_fast_decel(o_fast_decel), .o_mpg_count(o_mpg_count));

// File: test/mps_axis_model.sv
// Motion profile stand-in on the far side of the sequencer
`timescale 1ns/1ps
module mps_axis_model (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  input  wire logic               i_move_start,
  input  wire logic               i_move_rel,
  input  wire logic               i_itp_active,
  input  wire logic signed [31:0] i_move_target,
  input  wire logic [3:0]         i_lag,
  output logic                    o_move_done,
  output logic signed [31:0]      o_position
);
  // ***
  // Travel timing
  // ***
  logic [3:0] left;
  logic       itp_q;
  wire        itp_go = i_itp_active & ~itp_q;
  // Done drops with the command itself, no stale done is seen
  assign o_move_done = (left == 4'h0) & ~i_move_start & ~itp_go;
  always_ff @(posedge i_sys_clk) begin
    itp_q <= i_rst ? 1'b0 : i_itp_active;
    if (i_rst)
      left <= 4'h0;
    else if (i_move_start | itp_go)
      left <= i_lag;
    else if (left != 4'h0)
      left <= left - 4'h1;
    if (i_rst)
      o_position <= 32'h0;
    else if (i_move_start)
      o_position <= i_move_rel ? o_position + i_move_target : i_move_target;
  end
endmodule

// File: test/motion_program_sequencer_bench.sv
// Self-checking bench for the motion program sequencer
`timescale 1ns/1ps
`include "mps_defs.svh"
module motion_program_sequencer_bench;
  logic                         clk = 0, rst = 1, we = 0, start = 0;
  logic                         pin1 = 0, mpg = 0, done, itp_seen = 0;
  logic [`MPS_PC_W-1:0]         addr = '0;
  logic [`MPS_STEP_W-1:0]       data = '0;
  logic signed [`MPS_ARG_W-1:0] pos, tgt;
  logic                         busy, mst, mrel, mcont, interrupt_positioning_step, fdec;
  logic [`MPS_ARG_W-1:0]        cnt;
  logic [`MPS_PC_W-1:0]         step;
  logic [3:0]                   lag = 4'h2;
  int err_count = 0, tests_run = 0, seed = 93050, moves = 0;
  int q_tgt[$], q_rel[$];
  bit mon = 1;
  always #5 clk = ~clk;
  always @(posedge clk) lag <= 4'h2 + 4'($random(seed) & 32'h7);
  mps_sequencer dut (.i_sys_clk(clk), .i_rst(rst), .i_prog_we(we),
    .i_prog_addr(addr), .i_prog_data(data), .i_start(start),
    .i_program_input_one(pin1), .i_mpg_pulse(mpg), .i_move_done(done),
    .i_position(pos), .o_busy(busy), .o_move_start(mst), .o_move_rel(mrel),
    .o_move_cont(mcont), .o_move_target(tgt), .o_itp_active(interrupt_positioning_step),
    .o_fast_decel(fdec), .o_mpg_count(cnt), .o_step(step));
  mps_axis_model u_axis (.i_sys_clk(clk), .i_rst(rst), .i_move_start(mst),
    .i_move_rel(mrel), .i_itp_active(interrupt_positioning_step), .i_move_target(tgt),
    .i_lag(lag), .o_move_done(done), .o_position(pos));
  // ***
  // Tasks
  // ***
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wr(int a, logic [3:0] op, logic [31:0] arg);
    @(posedge clk);
    we <= 1'b1;
    addr <= a[7:0];
    data <= {op, arg};
  endtask
  task automatic go;
    @(posedge clk);
    we <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic pulse(int n);
    repeat (n) begin
      mpg <= 1'b1;
      repeat (6) @(posedge clk);
      mpg <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic wmv(int n);
    for (int k = 0; k < 3000 && moves < n; k++) @(posedge clk);
    chk("moves", n, moves);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Extra moves pop -1 so they always mismatch
  always @(posedge clk) begin
    if (interrupt_positioning_step === 1'b1) itp_seen <= 1'b1;
    if (mon && mst === 1'b1) begin
      moves <= moves + 1;
      if (q_tgt.size() == 0) q_tgt.push_back(-1);
      if (q_rel.size() == 0) q_rel.push_back(-1);
      chk("target", q_tgt.pop_front(), tgt);
      chk("rel", q_rel.pop_front(), {31'h0, mrel});
      chk("cont", 0, {31'h0, mcont});
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr(0, `MPS_OP_TIMES, 32'h2);
    wr(1, `MPS_OP_MOVE, 32'h64);
    wr(2, `MPS_OP_FOR, 32'h3);
    wr(3, `MPS_OP_MOVE, 32'h8000_0005);
    wr(4, `MPS_OP_NEXT, 32'h0);
    wr(5, `MPS_OP_COUNT, 32'h2);
    wr(6, `MPS_OP_DWELL, 32'h0);
    wr(7, `MPS_OP_SYNC, 32'h1);
    wr(8, `MPS_OP_ITP, 32'h3E8);
    wr(9, `MPS_OP_COUNT, 32'h0);
    wr(10, `MPS_OP_STOP, 32'h0);
    for (int r = 0; r < 8; r++) begin
      q_tgt.push_back(r % 4 ? 5 : 100);
      q_rel.push_back(r % 4 ? 1 : 0);
    end
    go;
    wmv(4);
    repeat (50) @(posedge clk);
    pulse(2);
    repeat (20) @(posedge clk);
    chk("count", 2, cnt);
    chk("held", 4, moves);
    pulse(1);
    repeat (50) @(posedge clk);
    chk("sync hold", 4, moves);
    pin1 <= 1'b1;
    wmv(5);
    chk("cleared", 0, cnt);
    wmv(8);
    pulse(3);
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
    chk("idle", 0, busy);
    chk("runs", 8, moves);
    chk("itp skip", 0, itp_seen);
    pin1 <= 1'b0;
    wr(0, `MPS_OP_MOVE, 32'h12C);
    wr(1, `MPS_OP_SYNC, 32'h1);
    wr(2, `MPS_OP_ITP, 32'h32);
    wr(3, `MPS_OP_STOP, 32'h0);
    q_tgt.push_back(300);
    q_rel.push_back(0);
    go;
    wmv(9);
    mon <= 1'b0;
    repeat (40) @(posedge clk);
    chk("itp wait", 0, itp_seen);
    pin1 <= 1'b1;
    for (int k = 0; k < 200 && interrupt_positioning_step !== 1'b1; k++) @(posedge clk);
    chk("itp", 1, interrupt_positioning_step);
    chk("decel", 1, fdec);
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
    chk("end", 0, busy);
    chk("itp pos", 350, pos);
    chk("step", 0, step);
    // Last trip is never reached, so a mid-run reset ends it
    wr(0, `MPS_OP_MOVE, 32'h8000_0028);
    wr(1, `MPS_OP_TRIP, 32'h8000_0014);
    wr(2, `MPS_OP_TRIP, 32'h172);
    wr(3, `MPS_OP_TRIP, 32'h1F4);
    wr(4, `MPS_OP_STOP, 32'h0);
    go;
    repeat (60) @(posedge clk);
    chk("trip pos", 390, pos);
    chk("trip hold", 1, busy);
    chk("trip step", 4, step);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst busy", 0, busy);
    chk("rst step", 0, step);
    complete_run;
  end
endmodule
